// ---- pkg/igds_pkg.sv ----
// Shared constants and types of the isolated gate drive sequencer
package igds_pkg;

  // Timing clock
  localparam int unsigned CLK_PERIOD_NS = 100;

  // Extended-off threshold: least time, rounded up
  localparam int unsigned EXT_OFF_NS    = 32000;
  localparam int unsigned EXT_OFF_CYC   = (EXT_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Pre-discharge duration: least time, rounded up, at least one cycle
  localparam int unsigned PREDIS_NS     = 20;
  localparam int unsigned PREDIS_CYC    = (PREDIS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Negative-off duration scale: tenths of pF, and ps per clock
  localparam int unsigned NEG_CAP_DPF   = 108;
  localparam int unsigned CLK_PERIOD_PS = CLK_PERIOD_NS * 1000;

  // Pulse repetition across the isolation transformer link
  localparam int unsigned TX_FAST_NS    = 1000;
  localparam int unsigned TX_SLOW_NS    = 4000;
  localparam int unsigned RX_FAST_WIN_NS = 2000;
  localparam int unsigned RX_WDOG_NS    = 10000;
  localparam int unsigned TX_FAST_CYC   = TX_FAST_NS / CLK_PERIOD_NS;
  localparam int unsigned TX_SLOW_CYC   = TX_SLOW_NS / CLK_PERIOD_NS;
  localparam int unsigned RX_FAST_WIN_CYC = RX_FAST_WIN_NS / CLK_PERIOD_NS;
  localparam int unsigned RX_WDOG_CYC   = RX_WDOG_NS / CLK_PERIOD_NS;

  // Supply lockout levels in mV
  localparam int unsigned VIN_ASSERT_MV  = 2850;
  localparam int unsigned VIN_HYST_MV    = 150;
  localparam int unsigned GATE_ON_MV     = 4500;
  localparam int unsigned SRC_ON_MV      = 5500;
  localparam int unsigned OUT_HYST_MV    = 300;

  // Widths
  localparam int unsigned VOLT_W = 16;
  localparam int unsigned RES_W  = 16;
  localparam int unsigned TMR_W  = 16;

  // Bridge switch word, closed = 1
  typedef struct packed {
    logic first_bridge_switch;
    logic second_bridge_switch;
    logic third_bridge_switch;
    logic fourth_bridge_switch;
  } igds_sw_t;

  // One transformer pulse: strobe and carried command state
  typedef struct packed {
    logic valid;
    logic on;
  } igds_pulse_t;

  // Switch patterns per phase
  localparam igds_sw_t SW_ON      = 4'h6;
  localparam igds_sw_t SW_OFF     = 4'hA;
  localparam igds_sw_t SW_EXT_OFF = 4'h9;
  localparam igds_sw_t SW_OPEN    = 4'h0;

  typedef enum logic [2:0] {
    ST_EXT_OFF,
    ST_PREDIS,
    ST_ON,
    ST_OFF_NEG,
    ST_OFF_ZERO
  } igds_state_t;

endpackage : igds_pkg

// ---- core/igds_link_rx.sv ----
// Output-side receiver of the isolation transformer link with watchdog
`timescale 1ns/1ps
`default_nettype none
module igds_link_rx #(
  parameter int unsigned FAST_WIN_CYC = igds_pkg::RX_FAST_WIN_CYC,
  parameter int unsigned WDOG_CYC     = igds_pkg::RX_WDOG_CYC
) (
  // Clock and reset
  input  wire logic                i_ref_clk,
  input  wire logic                i_rst,
  // Pulses from the transmitter
  input  wire igds_pkg::igds_pulse_t i_pulse,
  // Decoded link state
  output logic                     o_cmd_on,
  output logic                     o_ext_off,
  output logic                     o_link_fail
);

  logic [igds_pkg::TMR_W-1:0] gap_r;
  logic                       on_r;
  logic                       ext_r;
  logic                       fail_r;

  // Gap decode against the two windows
  wire slow_gap = (gap_r >= igds_pkg::TMR_W'(FAST_WIN_CYC));
  wire wdog_hit = (gap_r >= igds_pkg::TMR_W'(WDOG_CYC));

  // Gap counter restarts on every pulse, saturates at the watchdog limit
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      gap_r <= '0;
    end else if (i_pulse.valid) begin
      gap_r <= '0;
    end else if (!wdog_hit) begin
      gap_r <= gap_r + 1'b1;
    end
  end

  // Command, extended-off and watchdog flags
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      on_r   <= 1'b0;
      ext_r  <= 1'b1;
      fail_r <= 1'b1;
    end else if (i_pulse.valid) begin
      on_r   <= i_pulse.on;
      ext_r  <= ext_r & ~i_pulse.on & ~fail_r;   // Slow-rate off latches until an on pulse [RL8]
      fail_r <= 1'b0;                             // Any pulse recovers the link [RL6]
      if (!i_pulse.on && slow_gap) begin
        ext_r <= 1'b1;                            // Reduced repetition rate seen [RL8]
      end
    end else if (wdog_hit) begin
      on_r   <= 1'b0;                             // Pulses lost: safe off [RL6]
      ext_r  <= 1'b1;
      fail_r <= 1'b1;
    end
  end

  assign o_cmd_on    = on_r;
  assign o_ext_off   = ext_r;
  assign o_link_fail = fail_r;

endmodule : igds_link_rx
`default_nettype wire

// ---- core/igds_top.sv ----
// Isolated gate drive sequencer: transmitter, lockouts and output switch sequencing
//
// Functional notes
// [RL1] Output switches only change while input and output supplies are above lockout; input lockout forces extended off, a locked stage opens its switches.
// [RL2] Gate stage releases at 4.5 V, source stage at 5.5 V, 0.3 V hysteresis each.
// [RL3] Input lockout asserts below 2.85 V, releases 0.15 V higher.
// [RL4] Input lockout forces gate output low and source output high.
// [RL5] Transmitter repeats the present command as a continuous pulse train.
// [RL6] Receiver watchdog expires on missing pulses, recovers, and forces safe off.
// [RL7] After 32 us of off command the pulse rate is reduced.
// [RL8] Reduced rate opens third switch and closes fourth switch.
// [RL9] Negative-off duration equals timing resistance times 10.8 pF from each off start.
// [RL10] System keeps this duration between dead time and minimum off period.
// [RL11] Normal turn-on opens first switch and closes second switch.
// [RL12] Turn-on after extended off first closes third switch for about 20 ns; the sequencer holds it for PREDIS_CYC, one 100 ns clock.
// [RL13] All intervals are counted on the internal timing clock.
// [RL14] Turn-on before extended off skips the pre-discharge step.
`timescale 1ns/1ps
`default_nettype none
module igds_top #(
  parameter int unsigned EXT_OFF_CYC  = igds_pkg::EXT_OFF_CYC,
  parameter int unsigned TX_FAST_CYC  = igds_pkg::TX_FAST_CYC,
  parameter int unsigned TX_SLOW_CYC  = igds_pkg::TX_SLOW_CYC,
  parameter int unsigned PREDIS_CYC   = igds_pkg::PREDIS_CYC
) (
  // Clock and reset
  input  wire logic                          i_ref_clk,
  input  wire logic                          i_rst,
  // Command pin from the controller
  input  wire logic                          i_pwm,
  // Supply monitor codes in mV
  input  wire logic [igds_pkg::VOLT_W-1:0]   i_input_side_supply_mv,
  input  wire logic [igds_pkg::VOLT_W-1:0]   i_output_side_supply_mv,
  // Measured negative time resistor in ohm
  input  wire logic [igds_pkg::RES_W-1:0]    i_negative_time_resistor_ohm,
  // Bridge switches and pins
  output igds_pkg::igds_sw_t                 o_switch,
  output logic                               o_gate_side_output,
  output logic                               o_source_side_output,
  // Status
  output logic                               o_input_supply_lockout,
  output logic                               o_gate_supply_lockout,
  output logic                               o_source_supply_lockout,
  output logic                               o_negative_off_phase,
  output logic                               o_extended_off,
  output logic                               o_link_fail
);

  // Hysteresis comparator: asserted below assert level, released at release level
  function automatic logic lockout_next(input logic cur, input logic [igds_pkg::VOLT_W-1:0] mv,
                                        input int unsigned release_mv, input int unsigned assert_mv);
    logic res;
    res = cur;
    if (cur && (32'(mv) >= release_mv)) begin
      res = 1'b0;
    end else if (!cur && (32'(mv) < assert_mv)) begin
      res = 1'b1;
    end
    return res;
  endfunction : lockout_next

  // Negative-off cycles from resistance: ceil(R * 10.8 pF / period), at least one
  function automatic logic [igds_pkg::TMR_W-1:0] neg_cycles(input logic [igds_pkg::RES_W-1:0] ohm);
    logic [31:0] ps_x10;
    logic [31:0] cyc;
    ps_x10 = 32'(ohm) * igds_pkg::NEG_CAP_DPF;
    cyc    = (ps_x10 + 32'(igds_pkg::CLK_PERIOD_PS * 10) - 32'd1) / 32'(igds_pkg::CLK_PERIOD_PS * 10);
    if (cyc == 32'd0) begin
      cyc = 32'd1;
    end
    return cyc[igds_pkg::TMR_W-1:0];
  endfunction : neg_cycles

  // Pin synchroniser, first stage read only by the second
  logic pwm_meta_r;
  logic pwm_sync_r;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pwm_meta_r <= 1'b0;
      pwm_sync_r <= 1'b0;
    end else begin
      pwm_meta_r <= i_pwm;
      pwm_sync_r <= pwm_meta_r;
    end
  end

  // Supply lockouts, all asserted out of reset
  logic vin_lock_r;
  logic gate_lock_r;
  logic src_lock_r;
  wire  vin_lock_nxt  = lockout_next(vin_lock_r, i_input_side_supply_mv,
                                     igds_pkg::VIN_ASSERT_MV + igds_pkg::VIN_HYST_MV,
                                     igds_pkg::VIN_ASSERT_MV);                        // [RL3]
  wire  gate_lock_nxt = lockout_next(gate_lock_r, i_output_side_supply_mv, igds_pkg::GATE_ON_MV,
                                     igds_pkg::GATE_ON_MV - igds_pkg::OUT_HYST_MV);   // [RL2]
  wire  src_lock_nxt  = lockout_next(src_lock_r, i_output_side_supply_mv, igds_pkg::SRC_ON_MV,
                                     igds_pkg::SRC_ON_MV - igds_pkg::OUT_HYST_MV);    // [RL2]

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      vin_lock_r  <= 1'b1;
      gate_lock_r <= 1'b1;
      src_lock_r  <= 1'b1;
    end else begin
      vin_lock_r  <= vin_lock_nxt;
      gate_lock_r <= gate_lock_nxt;
      src_lock_r  <= src_lock_nxt;
    end
  end

  // Transmitter: an input lockout sends off, already marked extended
  wire tx_cmd = pwm_sync_r & ~vin_lock_r;                               // [RL4]
  logic                       tx_cmd_r;
  logic [igds_pkg::TMR_W-1:0] off_cnt_r;
  logic [igds_pkg::TMR_W-1:0] rep_cnt_r;
  igds_pkg::igds_pulse_t      pulse_r;

  wire tx_ext    = (off_cnt_r >= igds_pkg::TMR_W'(EXT_OFF_CYC)) | vin_lock_r; // [RL7] [RL4]
  wire [igds_pkg::TMR_W-1:0] rep_per = tx_ext ? igds_pkg::TMR_W'(TX_SLOW_CYC)
                                              : igds_pkg::TMR_W'(TX_FAST_CYC);
  wire tx_edge   = (tx_cmd != tx_cmd_r);
  wire tx_fire   = tx_edge | (rep_cnt_r + 1'b1 >= rep_per);

  // Off-time counter saturates; repetition restarts on each command edge
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      tx_cmd_r  <= 1'b0;
      off_cnt_r <= igds_pkg::TMR_W'(EXT_OFF_CYC);
      rep_cnt_r <= '0;
      pulse_r   <= '0;
    end else begin
      tx_cmd_r  <= tx_cmd;
      if (tx_cmd) begin
        off_cnt_r <= '0;
      end else if (!tx_ext) begin
        off_cnt_r <= off_cnt_r + 1'b1;                                  // [RL13]
      end
      rep_cnt_r <= tx_fire ? '0 : rep_cnt_r + 1'b1;
      pulse_r   <= '{valid: tx_fire, on: tx_cmd};                       // [RL5]
    end
  end

  // Output-side receiver
  logic rx_on;
  logic rx_ext;
  logic rx_fail;

  igds_link_rx u_rx (
    .i_ref_clk   (i_ref_clk),
    .i_rst       (i_rst),
    .i_pulse     (pulse_r),
    .o_cmd_on    (rx_on),
    .o_ext_off   (rx_ext),
    .o_link_fail (rx_fail)
  );

  // Output sequencer
  igds_pkg::igds_state_t      st_r;
  igds_pkg::igds_state_t      st_nxt;
  logic [igds_pkg::TMR_W-1:0] tmr_r;
  logic [igds_pkg::TMR_W-1:0] tmr_nxt;
  wire  tmr_done = (tmr_r <= igds_pkg::TMR_W'(1));
  wire  out_lock = gate_lock_r | src_lock_r;

  // Next phase; an output lockout freezes the phase, input lockout forces extended off
  always_comb begin
    st_nxt  = st_r;
    tmr_nxt = tmr_done ? tmr_r : tmr_r - 1'b1;                          // [RL13]
    if (vin_lock_r) begin
      st_nxt = igds_pkg::ST_EXT_OFF;                                    // [RL4]
    end else if (!out_lock) begin                                       // [RL1]
      unique case (st_r)
        igds_pkg::ST_ON: begin
          if (!rx_on) begin
            st_nxt  = igds_pkg::ST_OFF_NEG;
            tmr_nxt = neg_cycles(i_negative_time_resistor_ohm);         // [RL9]
          end
        end
        igds_pkg::ST_OFF_NEG, igds_pkg::ST_OFF_ZERO: begin
          if (rx_on) begin
            st_nxt = igds_pkg::ST_ON;                                   // [RL14]
          end else if (rx_ext) begin
            st_nxt = igds_pkg::ST_EXT_OFF;                              // [RL8]
          end else if (st_r == igds_pkg::ST_OFF_NEG && tmr_done) begin
            st_nxt = igds_pkg::ST_OFF_ZERO;                             // [RL9]
          end
        end
        igds_pkg::ST_EXT_OFF: begin
          if (rx_on) begin
            st_nxt  = igds_pkg::ST_PREDIS;                              // [RL12]
            tmr_nxt = igds_pkg::TMR_W'(PREDIS_CYC);
          end
        end
        igds_pkg::ST_PREDIS: begin
          if (!rx_on) begin
            st_nxt = igds_pkg::ST_EXT_OFF;
          end else if (tmr_done) begin
            st_nxt = igds_pkg::ST_ON;                                   // [RL12]
          end
        end
        default: begin
          st_nxt = igds_pkg::ST_EXT_OFF;
        end
      endcase
    end
  end

  // Switch pattern of the next phase; a locked stage holds both its switches open
  igds_pkg::igds_sw_t sw_phase;
  igds_pkg::igds_sw_t sw_nxt;
  assign sw_phase = (st_nxt == igds_pkg::ST_ON)      ? igds_pkg::SW_ON :       // [RL11]
                    (st_nxt == igds_pkg::ST_EXT_OFF) ? igds_pkg::SW_EXT_OFF :  // [RL8]
                                                       igds_pkg::SW_OFF;       // [RL12]
  assign sw_nxt   = '{first_bridge_switch:  sw_phase.first_bridge_switch  & ~gate_lock_r,  // [RL2]
                      second_bridge_switch: sw_phase.second_bridge_switch & ~gate_lock_r,
                      third_bridge_switch:  sw_phase.third_bridge_switch  & ~src_lock_r,
                      fourth_bridge_switch: sw_phase.fourth_bridge_switch & ~src_lock_r};

  // Phase, timer and registered outputs
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_r                    <= igds_pkg::ST_EXT_OFF;
      tmr_r                   <= '0;
      o_switch                <= igds_pkg::SW_OPEN;
      o_gate_side_output      <= 1'b0;
      o_source_side_output    <= 1'b0;
      o_input_supply_lockout  <= 1'b1;
      o_gate_supply_lockout   <= 1'b1;
      o_source_supply_lockout <= 1'b1;
      o_negative_off_phase    <= 1'b0;
      o_extended_off          <= 1'b1;
      o_link_fail             <= 1'b1;
    end else begin
      st_r                    <= st_nxt;
      tmr_r                   <= tmr_nxt;
      o_switch                <= sw_nxt;
      o_gate_side_output      <= sw_nxt.second_bridge_switch;
      o_source_side_output    <= sw_nxt.fourth_bridge_switch;
      o_input_supply_lockout  <= vin_lock_r;
      o_gate_supply_lockout   <= gate_lock_r;
      o_source_supply_lockout <= src_lock_r;
      o_negative_off_phase    <= (st_nxt == igds_pkg::ST_OFF_NEG);
      o_extended_off          <= (st_nxt == igds_pkg::ST_EXT_OFF);
      o_link_fail             <= rx_fail;
    end
  end

endmodule : igds_top
`default_nettype wire

// ---- dv/igds_pwm_ctrl.sv ----
// PWM controller model that drives the command pin
`timescale 1ns/1ps
`default_nettype none
module igds_pwm_ctrl (
  // Clock and control from the bench
  input  wire logic        i_ref_clk,
  input  wire logic        i_run,
  input  wire logic [15:0] i_on_cyc,
  input  wire logic [15:0] i_off_cyc,
  // Command pin
  output logic             o_pwm
);
  logic [15:0] cnt_r;
  // Falling edge keeps pin changes clear of the sampling edge; stopped model holds the pin low
  always @(negedge i_ref_clk) begin
    if (!i_run) begin
      o_pwm <= 1'b0;
      cnt_r <= 16'h0;
    end else if (o_pwm && cnt_r + 16'h1 >= i_on_cyc) begin
      o_pwm <= 1'b0;
      cnt_r <= 16'h0;
    end else if (!o_pwm && cnt_r + 16'h1 >= i_off_cyc) begin // Off period above negative time
      o_pwm <= 1'b1;
      cnt_r <= 16'h0;
    end else begin
      cnt_r <= cnt_r + 16'h1;
    end
  end
endmodule : igds_pwm_ctrl
`default_nettype wire

// ---- dv/igds_props.sv ----
// Checker of switch sequencing seen at the top ports
`timescale 1ns/1ps
`default_nettype none
module igds_props #(
  parameter int unsigned EXT_OFF_CYC = igds_pkg::EXT_OFF_CYC
) (
  // Clock, reset and timing resistor
  input wire logic                       i_ref_clk,
  input wire logic                       i_rst,
  input wire logic [igds_pkg::RES_W-1:0] i_negative_time_resistor_ohm,
  // Watched outputs
  input wire igds_pkg::igds_sw_t         o_switch,
  input wire logic                       o_gate_side_output,
  input wire logic                       o_source_side_output,
  input wire logic                       o_input_supply_lockout,
  input wire logic                       o_gate_supply_lockout,
  input wire logic                       o_source_supply_lockout,
  input wire logic                       o_negative_off_phase,
  input wire logic                       o_extended_off,
  input wire logic                       o_link_fail
);
  logic [15:0] neg_cnt_r;
  logic [15:0] off_cnt_r;
  logic        locked;
  logic [31:0] t1_cyc;
  // Any supply flag freezes or overrides the sequence
  assign locked = o_input_supply_lockout | o_gate_supply_lockout | o_source_supply_lockout;
  assign t1_cyc = (32'(i_negative_time_resistor_ohm) * igds_pkg::NEG_CAP_DPF
                   + igds_pkg::CLK_PERIOD_PS * 10 - 1) / (igds_pkg::CLK_PERIOD_PS * 10);
  // Length of negative phase and of gate-low time; off count saturates
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !o_negative_off_phase) neg_cnt_r <= 16'h0;
    else neg_cnt_r <= neg_cnt_r + 16'h1;
    if (i_rst || o_gate_side_output) off_cnt_r <= 16'h0;
    else if (off_cnt_r != 16'hFFFF) off_cnt_r <= off_cnt_r + 16'h1;
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  a_fail_safe: assert property (o_link_fail && $past(o_link_fail) |-> !o_gate_side_output)
    else $error("gate output high while link failed");
  a_pin_map: assert property (o_gate_side_output == o_switch.second_bridge_switch
    && o_source_side_output == o_switch.fourth_bridge_switch
    && !(o_gate_side_output && o_source_side_output)) else $error("pin and switch disagree");
  a_link_kept: assert property (!$past(o_link_fail) |-> !o_link_fail)
    else $error("link lost although pulses repeat");
  a_gate_open: assert property (o_gate_supply_lockout && $past(o_gate_supply_lockout)
    |-> !o_switch.first_bridge_switch && !o_switch.second_bridge_switch) else $error("locked gate stage closed");
  a_input_force: assert property (o_input_supply_lockout && $past(o_input_supply_lockout)
    && !o_source_supply_lockout && !$past(o_source_supply_lockout)
    |-> o_switch.fourth_bridge_switch && !o_gate_side_output) else $error("input lockout not forcing off");
  a_predis_len: assert property (!locked && o_switch == igds_pkg::SW_OFF
    && $past(o_switch) == igds_pkg::SW_EXT_OFF |=> o_switch == igds_pkg::SW_ON || locked)
    else $error("pre-discharge not one cycle");
  a_on_entry: assert property ($rose(o_gate_side_output) && !$past(locked)
    |-> $past(o_switch) == igds_pkg::SW_OFF) else $error("turn-on from wrong pattern");
  a_neg_len: assert property ($fell(o_negative_off_phase) && !o_gate_side_output && !locked
    |-> neg_cnt_r == t1_cyc[15:0]) else $error("negative phase length wrong");
  a_ext_early: assert property ($rose(o_extended_off) && !o_link_fail && !locked && !$past(locked)
    |-> off_cnt_r >= EXT_OFF_CYC) else $error("extended off too early");
  c_ext_rise: cover property ($rose(o_extended_off));
  c_predis: cover property (o_switch == igds_pkg::SW_OFF ##1 o_switch == igds_pkg::SW_ON);
  c_neg_end: cover property ($fell(o_negative_off_phase));
endmodule : igds_props
bind igds_top igds_props #(.EXT_OFF_CYC(EXT_OFF_CYC)) u_igds_props (.i_ref_clk, .i_rst,
  .i_negative_time_resistor_ohm, .o_switch, .o_gate_side_output, .o_source_side_output,
  .o_input_supply_lockout, .o_gate_supply_lockout, .o_source_supply_lockout,
  .o_negative_off_phase, .o_extended_off, .o_link_fail);
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench of the isolated gate drive sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int unsigned EXT_CYC = 40;
  typedef struct packed { logic [15:0] vi; logic [15:0] vo; logic [2:0] lk; } igds_row_t;
  logic               clk, rst, pwm, run;
  logic [15:0]        on_cyc, off_cyc, vin, vout, res;
  igds_pkg::igds_sw_t sw;
  logic               gate_o, src_o, lk_in, lk_g, lk_s, neg, ext, fail;
  int                 err_total, checked, n;
  // Supply codes and expected {input, gate, source} lockouts, in order
  igds_row_t rows [8] = '{'{16'h0BB8, 16'h157C, 3'h0}, '{16'h0B22, 16'h1450, 3'h0},
    '{16'h0B21, 16'h144F, 3'h5}, '{16'h0BB7, 16'h157B, 3'h5}, '{16'h0BB8, 16'h1067, 3'h3},
    '{16'h0BB8, 16'h1193, 3'h3}, '{16'h0BB8, 16'h1194, 3'h1}, '{16'h0CE4, 16'h1F40, 3'h0}};
  igds_top #(.EXT_OFF_CYC(EXT_CYC)) u_igds_top (.i_ref_clk(clk), .i_rst(rst), .i_pwm(pwm),
    .i_input_side_supply_mv(vin), .i_output_side_supply_mv(vout), .i_negative_time_resistor_ohm(res),
    .o_switch(sw), .o_gate_side_output(gate_o), .o_source_side_output(src_o),
    .o_input_supply_lockout(lk_in), .o_gate_supply_lockout(lk_g), .o_source_supply_lockout(lk_s),
    .o_negative_off_phase(neg), .o_extended_off(ext), .o_link_fail(fail));
  igds_pwm_ctrl u_igds_pwm_ctrl (.i_ref_clk(clk), .i_run(run), .i_on_cyc(on_cyc), .i_off_cyc(off_cyc),
    .o_pwm(pwm));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic conclude();
    $display("Counts: checked=%0d mismatches=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One bounded wait step; running out ends the run
  task automatic step();
    @(negedge clk);
    n++;
    if (n > 400) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, n, 400);
      conclude();
    end
  endtask : step
  initial begin
    rst = 1'b1;
    run = 1'b0;
    on_cyc = 16'h001E;
    off_cyc = 16'h0014;
    vin = 16'h0000;
    vout = 16'h0000;
    res = 16'hAFC8;
    err_total = 0;
    checked = 0;
    n = 0;
    repeat (6) @(negedge clk);
    chk({7'h0, sw, lk_in, lk_g, lk_s, ext, fail}, 16'h001F);
    rst = 1'b0;
    // Lockout levels and hysteresis, one row at a time
    foreach (rows[i]) begin
      vin = rows[i].vi;
      vout = rows[i].vo;
      repeat (3) @(negedge clk);
      chk({13'h0, lk_in, lk_g, lk_s}, {13'h0, rows[i].lk});
    end
    $display("Test lockout levels done");
    n = 0;
    while (fail !== 1'b0) step();
    repeat (2) @(negedge clk);
    chk({12'h0, sw}, 16'h0009);
    // First pulse after extended off, then negative phase, then early turn-on
    run = 1'b1;
    n = 0;
    while (sw === igds_pkg::SW_EXT_OFF) step();
    chk({12'h0, sw}, 16'h000A);
    @(negedge clk);
    chk({12'h0, sw}, 16'h0006);
    n = 0;
    while (neg !== 1'b1) step();
    n = 0;
    while (neg === 1'b1) step();
    chk(n[15:0], 16'h0005);
    n = 0;
    while (sw === igds_pkg::SW_OFF) step();
    chk({11'h0, ext, sw}, 16'h0006);
    $display("Test pulse sequence done");
    run = 1'b0;
    n = 0;
    while (ext !== 1'b1) step();
    chk({15'h0, n >= EXT_CYC}, 16'h0001);
    chk({15'h0, n <= EXT_CYC + igds_pkg::TX_SLOW_CYC + 12}, 16'h0001);
    chk({12'h0, sw}, 16'h0009);
    $display("Test extended off done");
    // Input lockout while on forces gate low and source high
    on_cyc = 16'h03E8;
    run = 1'b1;
    n = 0;
    while (gate_o !== 1'b1) step();
    vin = 16'h0AF0;
    repeat (4) @(negedge clk);
    chk({10'h0, gate_o, src_o, sw}, 16'h0019);
    vin = 16'h0CE4;
    n = 0;
    while (gate_o !== 1'b1) step();
    // Source stage locked: turn-off command must not move the switches
    vout = 16'h1388;
    repeat (3) @(negedge clk);
    run = 1'b0;
    repeat (20) @(negedge clk);
    chk({15'h0, gate_o}, 16'h0001);
    vout = 16'h1F40;
    n = 0;
    while (ext !== 1'b1) step();
    chk({12'h0, sw}, 16'h0009);
    chk({15'h0, fail}, 16'h0000);
    $display("Test lockout override done");
    conclude();
  end
endmodule : tb
`default_nettype wire
